//--- design/tlr_consts.svh
`ifndef TLR_CONSTS_SVH
`define TLR_CONSTS_SVH
`define TLR_A_CTRL 8'h00
`define TLR_A_SCALE 8'h04
`define TLR_A_TIMER 8'h08
`define TLR_A_STAT 8'h0c
`define TLR_A_SMAP 8'h10
`define TLR_A_SMAP_END 8'h30
`define TLR_A_POSP 8'h40
`define TLR_A_POSP_END 8'h54
`define TLR_A_POST 8'h60
`define TLR_A_POST_END 8'h74
`define TLR_CF_REM 1:0
`define TLR_CF_DUMP 3:2
`define TLR_CF_START 5:4
`define TLR_CTRL_RST 8'h00
`define TLR_PPT_RST 16'h0064
`define TLR_PAR_MASK 20'h4077f
`define TLR_DISP_MAX 24'sh0d2eff
`define TLR_DISP_MIN 24'shfa81c1
`define TLR_NLOC 5
`define TLR_NSER 8
`define TLR_SRC_ZERO 3'h5
`define TLR_SRC_START 3'h6
`define TLR_SRC_NONE 3'h7
`endif

//--- design/tlr_locator.sv
`include "tlr_consts.svh"
`default_nettype none
module tlr_locator import tlr_pkg::*; (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire tlr_keys_s local_keys_i,
    input wire tlr_keys_s par_keys_i,
    input wire logic [7:0] ser_keys_i,
    input wire logic tacho_pulse_i,
    input wire logic tacho_fwd_i,
    input wire logic capstan_pulse_i,
    input wire logic capstan_fwd_i,
    input wire logic dump_i,
    input wire logic tape_end_i,
    input wire logic tape_break_i,
    input wire logic tape_moving_i,
    output tlr_drive_s drive_o,
    output logic lifter_defeat_o,
    output logic fader_ready_o,
    output logic remote_lamp_o,
    output logic arm_lamp_o,
    output logic aux_ind_o,
    output logic show_pos_o,
    output logic signed [23:0] disp_o,
    output logic underflow_o,
    output logic overflow_o
);
    // ****************************************************************
    // State and retained position store
    // ****************************************************************
    tlr_state_s st_ff;
    tlr_state_s nxt_st;
    // Positions deliberately carry no reset so they outlive a reset pulse; software reloads them after power-up.
    logic signed [31:0] posp_ff [`TLR_NLOC];
    logic signed [23:0] post_ff [`TLR_NLOC];
    logic nxt_wp;
    logic nxt_wt;
    logic [2:0] nxt_widx;
    logic signed [31:0] nxt_wpos;
    logic signed [23:0] nxt_wten;
    tlr_keys_s act;
    tlr_keys_s press;
    tlr_keys_s ser_map;
    logic local_ok;
    logic remote_ok;
    logic cnt_pulse;
    logic cnt_fwd;
    logic halt;
    logic loc_hit;
    logic [2:0] loc_k;
    logic signed [23:0] act_rnd;

    function automatic logic [39:0] step(input logic signed [23:0] t, input logic [15:0] f,
                                         input logic up, input logic [15:0] ppt);
        logic [39:0] r;
        r = {t, f};
        if (up) begin
            if (16'(f + 16'h0001) >= ppt) begin
                r = {24'(t + 24'sh000001), 16'h0000};
            end else begin
                r = {t, 16'(f + 16'h0001)};
            end
        end else if (f == 16'h0000) begin
            r = {24'(t - 24'sh000001), 16'(ppt - 16'h0001)};
        end else begin
            r = {t, 16'(f - 16'h0001)};
        end
        return r;
    endfunction

    // Half a count or more rounds the tenths upward rather than cutting it off.
    function automatic logic signed [23:0] rnd(input logic signed [23:0] t, input logic [15:0] f,
                                               input logic [15:0] ppt);
        return ({f, 1'b0} >= {1'b0, ppt}) ? 24'(t + 24'sh000001) : t;
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_wp = 1'b0;
        nxt_wt = 1'b0;
        nxt_widx = 3'h0;
        nxt_wpos = st_ff.tape_pos;
        nxt_wten = 24'sh000000;
        loc_hit = 1'b0;
        loc_k = 3'h0;
        ser_map = '0;
        for (int i = 0; i < `TLR_NSER; i++) begin
            if (ser_keys_i[i]) begin
                ser_map[st_ff.smap[i * 5 +: 5]] = 1'b1;
            end
        end
        local_ok = (st_ff.cfg[`TLR_CF_REM] != REM_EXCL) || !st_ff.rem_on;
        remote_ok = (st_ff.cfg[`TLR_CF_REM] == REM_NONE) || st_ff.rem_on;
        act = (local_ok ? local_keys_i : '0) |
              (remote_ok ? ((par_keys_i & `TLR_PAR_MASK) | ser_map) : '0);
        // The toggle must stay reachable from either side, else exclusive mode could lock itself out.
        act.remote = local_keys_i.remote | ser_map.remote;
        press = act & ~st_ff.prev;
        nxt_st.prev = act;
        nxt_st.lifter = act.lifter;
        nxt_st.fader = act.fader;
        if (press.remote) begin
            nxt_st.rem_on = !st_ff.rem_on;
        end
        nxt_st.rem_lamp = (st_ff.cfg[`TLR_CF_REM] == REM_NONE) || nxt_st.rem_on;

        // Tape position and both counters move together so locate targets stay valid.
        cnt_pulse = dump_i ? capstan_pulse_i : tacho_pulse_i;
        cnt_fwd = dump_i ? capstan_fwd_i : tacho_fwd_i;
        halt = tape_end_i || tape_break_i ||
               (dump_i && (st_ff.cfg[`TLR_CF_DUMP] == DUMP_B || st_ff.cfg[`TLR_CF_DUMP] == DUMP_D));
        if (cnt_pulse && !halt) begin
            nxt_st.tape_pos = cnt_fwd ? 32'(st_ff.tape_pos + 32'sh1) : 32'(st_ff.tape_pos - 32'sh1);
            {nxt_st.main_t, nxt_st.main_f} = step(st_ff.main_t, st_ff.main_f, cnt_fwd, st_ff.ppt);
            {nxt_st.aux_t, nxt_st.aux_f} = step(st_ff.aux_t, st_ff.aux_f, cnt_fwd, st_ff.ppt);
        end
        if (press.clear) begin
            if (st_ff.aux_sel) begin
                nxt_st.aux_t = 24'sh000000;
                nxt_st.aux_f = 16'h0000;
                nxt_st.zero_aux = st_ff.tape_pos;
            end else begin
                nxt_st.main_t = 24'sh000000;
                nxt_st.main_f = 16'h0000;
                nxt_st.zero_main = st_ff.tape_pos;
            end
        end
        if (press.aux) begin
            nxt_st.aux_sel = !st_ff.aux_sel;
        end
        if (press.arm) begin
            nxt_st.arm = 1'b1;
        end
        if (press != '0) begin
            nxt_st.show = 1'b0;
        end

        // ************************************************************
        // Transport and locate sequencing
        // ************************************************************
        act_rnd = st_ff.aux_sel ? rnd(st_ff.aux_t, st_ff.aux_f, st_ff.ppt) : rnd(st_ff.main_t, st_ff.main_f, st_ff.ppt);
        if (st_ff.mode == MD_LOC && st_ff.tape_pos == st_ff.target) begin
            case (st_ff.fin)
                FIN_PLAY: nxt_st.mode = MD_PLAY;
                FIN_REC: nxt_st.mode = MD_REC;
                default: nxt_st.mode = MD_STOP;
            endcase
            nxt_st.src = `TLR_SRC_NONE;
        end
        for (int k = `TLR_NLOC - 1; k >= 0; k--) begin
            if (press.loc[k]) begin
                loc_hit = 1'b1;
                loc_k = 3'(k);
            end
        end
        if (press.stop || press.edit || press.fwd || press.rew) begin
            nxt_st.mode = press.stop || press.edit ? MD_STOP : (press.fwd ? MD_FWD : MD_REW);
            nxt_st.src = `TLR_SRC_NONE;
        end else if (press.rewind_then_play_key) begin
            nxt_st.mode = MD_BKSP;
        end else if (st_ff.mode == MD_BKSP && !act.rewind_then_play_key) begin
            nxt_st.mode = MD_PLAY;
        end else if (press.play) begin
            if (st_ff.mode == MD_LOC) begin
                nxt_st.fin = act.rec ? FIN_REC : FIN_PLAY;
            end else begin
                if (st_ff.mode == MD_STOP && !tape_moving_i) begin
                    nxt_st.start_pos = st_ff.tape_pos;
                end
                nxt_st.mode = act.rec ? MD_REC : MD_PLAY;
            end
        end else if (press.zero) begin
            nxt_st.mode = MD_LOC;
            nxt_st.src = `TLR_SRC_ZERO;
            nxt_st.target = st_ff.aux_sel ? st_ff.zero_aux : st_ff.zero_main;
            nxt_st.fin = FIN_STOP;
        end else if (press.start) begin
            nxt_st.mode = MD_LOC;
            nxt_st.src = `TLR_SRC_START;
            nxt_st.target = st_ff.start_pos;
            case (st_ff.cfg[`TLR_CF_START])
                2'b01: nxt_st.fin = FIN_PLAY;
                2'b10: nxt_st.fin = FIN_REC;
                default: nxt_st.fin = FIN_STOP;
            endcase
        end else if (loc_hit) begin
            if (st_ff.arm) begin
                nxt_wp = 1'b1;
                nxt_wt = 1'b1;
                nxt_widx = loc_k;
                nxt_wten = act_rnd;
                nxt_st.arm = 1'b0;
            end else if ((st_ff.mode == MD_LOC && st_ff.src == loc_k) ||
                         (st_ff.mode == MD_STOP && act.stop)) begin
                nxt_st.show = 1'b1;
                nxt_st.show_idx = loc_k;
            end else begin
                nxt_st.mode = MD_LOC;
                nxt_st.src = loc_k;
                nxt_st.target = posp_ff[loc_k];
                nxt_st.fin = FIN_STOP;
            end
        end

        // ************************************************************
        // Register port
        // ************************************************************
        if (wr_i) begin
            if (addr_i == `TLR_A_CTRL) begin
                nxt_st.cfg = wdata_i[7:0];
            end else if (addr_i == `TLR_A_SCALE && wdata_i[15:0] != 16'h0000) begin
                nxt_st.ppt = wdata_i[15:0];
                nxt_st.main_f = 16'h0000;
                nxt_st.aux_f = 16'h0000;
            end else if (addr_i == `TLR_A_TIMER) begin
                nxt_st.main_t = wdata_i[23:0];
                nxt_st.main_f = 16'h0000;
                nxt_st.zero_main = 32'(st_ff.tape_pos - 32'($signed(wdata_i[23:0]) * $signed({1'b0, st_ff.ppt})));
            end else if (addr_i >= `TLR_A_SMAP && addr_i < `TLR_A_SMAP_END) begin
                nxt_st.smap[addr_i[4:2] * 5 +: 5] = wdata_i[4:0];
            end else if (addr_i >= `TLR_A_POSP && addr_i < `TLR_A_POSP_END) begin
                nxt_wp = 1'b1;
                nxt_widx = 3'(addr_i[7:2] - 6'(`TLR_A_POSP >> 2));
                nxt_wpos = wdata_i;
            end else if (addr_i >= `TLR_A_POST && addr_i < `TLR_A_POST_END) begin
                nxt_wt = 1'b1;
                nxt_widx = 3'(addr_i[7:2] - 6'(`TLR_A_POST >> 2));
                nxt_wten = wdata_i[23:0];
            end
        end
        nxt_st.rdata = 32'h0000_0000;
        if (rd_i) begin
            if (addr_i == `TLR_A_CTRL) begin
                nxt_st.rdata = {24'h000000, st_ff.cfg};
            end else if (addr_i == `TLR_A_SCALE) begin
                nxt_st.rdata = {16'h0000, st_ff.ppt};
            end else if (addr_i == `TLR_A_TIMER) begin
                nxt_st.rdata = 32'(signed'(rnd(st_ff.main_t, st_ff.main_f, st_ff.ppt)));
            end else if (addr_i == `TLR_A_STAT) begin
                nxt_st.rdata = {16'h0000, 1'b0, st_ff.src, 1'b0, st_ff.mode,
                                st_ff.under, st_ff.over, st_ff.show, st_ff.aux_sel,
                                st_ff.arm, st_ff.rem_lamp, st_ff.fin};
            end else if (addr_i >= `TLR_A_SMAP && addr_i < `TLR_A_SMAP_END) begin
                nxt_st.rdata = {27'h0000000, st_ff.smap[addr_i[4:2] * 5 +: 5]};
            end else if (addr_i >= `TLR_A_POSP && addr_i < `TLR_A_POSP_END) begin
                nxt_st.rdata = posp_ff[3'(addr_i[7:2] - 6'(`TLR_A_POSP >> 2))];
            end else if (addr_i >= `TLR_A_POST && addr_i < `TLR_A_POST_END) begin
                nxt_st.rdata = 32'(post_ff[3'(addr_i[7:2] - 6'(`TLR_A_POST >> 2))]);
            end
        end

        // ************************************************************
        // Display and drive outputs
        // ************************************************************
        nxt_st.disp = st_ff.show ? post_ff[st_ff.show_idx] : act_rnd;
        nxt_st.under = nxt_st.disp < `TLR_DISP_MIN;
        nxt_st.over = nxt_st.disp > `TLR_DISP_MAX;
        nxt_st.drv.fwd = nxt_st.mode == MD_FWD || (nxt_st.mode == MD_LOC && nxt_st.target > nxt_st.tape_pos);
        nxt_st.drv.rew = nxt_st.mode == MD_REW || nxt_st.mode == MD_BKSP ||
                         (nxt_st.mode == MD_LOC && nxt_st.target < nxt_st.tape_pos);
        nxt_st.drv.play = nxt_st.mode == MD_PLAY || nxt_st.mode == MD_REC;
        nxt_st.drv.rec = nxt_st.mode == MD_REC;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= '0;
            st_ff.src <= `TLR_SRC_NONE;
            st_ff.cfg <= `TLR_CTRL_RST;
            st_ff.ppt <= `TLR_PPT_RST;
            st_ff.rem_lamp <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk_i) begin
        if (nxt_wp) begin
            posp_ff[nxt_widx] <= nxt_wpos;
        end
        if (nxt_wt) begin
            post_ff[nxt_widx] <= nxt_wten;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign drive_o = st_ff.drv;
    assign lifter_defeat_o = st_ff.lifter;
    assign fader_ready_o = st_ff.fader;
    assign remote_lamp_o = st_ff.rem_lamp;
    assign arm_lamp_o = st_ff.arm;
    assign aux_ind_o = st_ff.aux_sel;
    assign show_pos_o = st_ff.show;
    assign disp_o = st_ff.disp;
    assign underflow_o = st_ff.under;
    assign overflow_o = st_ff.over;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_store;
        st_ff.arm && loc_hit && !press.stop && !press.edit && !press.fwd && !press.rew &&
        !press.rewind_then_play_key && !press.play && !press.zero && !press.start && !(st_ff.mode == MD_BKSP);
    endsequence
    sequence s_arrive_play;
        st_ff.mode == MD_LOC && st_ff.tape_pos == st_ff.target && st_ff.fin == FIN_PLAY && press == '0;
    endsequence

    a_store_disarm: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_store |=> !arm_lamp_o && posp_ff[$past(loc_k)] == $past(st_ff.tape_pos))
        else $error("store did not disarm or save");
    a_abort_locate: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_ff.mode == MD_LOC && press.stop |=> !drive_o.fwd && !drive_o.rew ##1 st_ff.mode == MD_STOP)
        else $error("stop did not abort locate");
    a_arrive_play: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_arrive_play |=> st_ff.mode == MD_PLAY ##1 drive_o.play)
        else $error("locate did not end in play");
    a_clear_main: assert property (@(posedge clk_i) disable iff (!nrst_i)
        press.clear && !st_ff.aux_sel && !wr_i |=> st_ff.main_t == 24'sh000000 && st_ff.zero_main == $past(st_ff.tape_pos))
        else $error("clear did not zero counter");
    a_remote_none: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_ff.cfg[`TLR_CF_REM] == REM_NONE [*2] |-> remote_lamp_o)
        else $error("remote lamp dark without remote setting");
    a_halt_end: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tape_end_i && !press.clear && !wr_i |=> $stable(st_ff.tape_pos) && $stable(st_ff.main_t))
        else $error("counter moved at tape end");
    a_aux_toggle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        press.aux |=> aux_ind_o != $past(aux_ind_o))
        else $error("aux key did not toggle");
    a_over_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !st_ff.show && act_rnd > `TLR_DISP_MAX |=> overflow_o && !underflow_o)
        else $error("overflow not flagged");
    a_excl_local: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_ff.cfg[`TLR_CF_REM] == REM_EXCL && st_ff.rem_on |-> !local_ok && remote_ok)
        else $error("local keys live under exclusive remote");
    a_keep_pos: assert property (@(posedge clk_i) disable iff (!nrst_i)
        press.clear && !wr_i |=> $stable(posp_ff[0]) && $stable(post_ff[0]))
        else $error("clear altered stored position");
endmodule // tlr_locator
`default_nettype wire

//--- design/tlr_pkg.sv
`default_nettype none
package tlr_pkg;
    typedef enum logic [1:0] {REM_NONE = 2'b00, REM_EXCL = 2'b01, REM_SHARED = 2'b10} tlr_rem_e;
    typedef enum logic [1:0] {DUMP_A = 2'b00, DUMP_B = 2'b01, DUMP_C = 2'b10, DUMP_D = 2'b11} tlr_dump_e;
    typedef enum logic [1:0] {FIN_STOP = 2'b00, FIN_PLAY = 2'b01, FIN_REC = 2'b10} tlr_fin_e;
    typedef enum logic [2:0] {
        MD_STOP = 3'b000, MD_PLAY = 3'b001, MD_REC = 3'b010, MD_FWD = 3'b011,
        MD_REW = 3'b100, MD_LOC = 3'b101, MD_BKSP = 3'b110
    } tlr_mode_e;
    typedef struct packed {
        logic remote;
        logic rewind_then_play_key;
        logic aux;
        logic arm;
        logic [4:0] loc;
        logic start;
        logic zero;
        logic clear;
        logic edit;
        logic stop;
        logic rew;
        logic fwd;
        logic rec;
        logic play;
        logic lifter;
        logic fader;
    } tlr_keys_s;
    typedef struct packed {
        logic rec;
        logic play;
        logic rew;
        logic fwd;
    } tlr_drive_s;
    typedef struct packed {
        tlr_mode_e mode;
        tlr_fin_e fin;
        logic [2:0] src;
        logic signed [31:0] target;
        logic signed [31:0] tape_pos;
        logic signed [31:0] zero_main;
        logic signed [31:0] zero_aux;
        logic signed [31:0] start_pos;
        logic signed [23:0] main_t;
        logic signed [23:0] aux_t;
        logic [15:0] main_f;
        logic [15:0] aux_f;
        tlr_keys_s prev;
        logic aux_sel;
        logic arm;
        logic rem_on;
        logic rem_lamp;
        logic show;
        logic [2:0] show_idx;
        logic [7:0] cfg;
        logic [15:0] ppt;
        logic [39:0] smap;
        logic [31:0] rdata;
        logic signed [23:0] disp;
        logic under;
        logic over;
        tlr_drive_s drv;
        logic lifter;
        logic fader;
    } tlr_state_s;
endpackage : tlr_pkg
`default_nettype wire

//--- verif/tb_tape_locator_timer_remote.sv
`include "tlr_consts.svh"
`default_nettype none
module tb_tape_locator_timer_remote import tlr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_seen = 1'b0;
    logic [31:0] rdata;
    tlr_keys_s keys_l, keys_p;
    logic [7:0] keys_s;
    logic tp = 1'b0;
    logic tdir = 1'b0;
    logic tend = 1'b0;
    tlr_drive_s drv;
    logic rem_lamp, arm_lamp;
    logic [23:0] disp;
    logic under;
    logic over;
    logic aux_ind;
    logic [31:0] exp_q[$];
    logic [31:0] rng = 32'h00001a45;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    always #12.5 clk_i = ~clk_i;
    tlr_keypad_model tlr_keypad_model_inst (.clk_i(clk_i), .local_keys_o(keys_l), .par_keys_o(keys_p),
        .ser_keys_o(keys_s));
    tlr_locator tlr_locator_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .local_keys_i(keys_l), .par_keys_i(keys_p), .ser_keys_i(keys_s),
        .tacho_pulse_i(tp), .tacho_fwd_i(tdir), .capstan_pulse_i(1'b0), .capstan_fwd_i(1'b0), .dump_i(1'b0),
        .tape_end_i(tend), .tape_break_i(1'b0), .tape_moving_i(1'b0), .drive_o(drv), .lifter_defeat_o(),
        .fader_ready_o(), .remote_lamp_o(rem_lamp), .arm_lamp_o(arm_lamp), .aux_ind_o(aux_ind), .show_pos_o(),
        .disp_o(disp), .underflow_o(under), .overflow_o(over));
    // ****
    // Checking, bus cycles and tape motion.
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        tests_run++;
        if (seen !== expv) begin
            fails++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask
    task automatic close_out();
        $display("Mismatches %0d of %0d compares", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    // The expected word is queued; the watcher pops it when the answer stands.
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic spool(input int cnt, input logic fwd);
        @(posedge clk_i);
        tp <= 1'b1;
        tdir <= fwd;
        repeat (cnt) @(posedge clk_i);
        tp <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic see_drive(input logic [3:0] e);
        @(negedge clk_i);
        check({28'h0, drv}, {28'h0, e});
    endtask
    always @(posedge clk_i) begin
        rd_seen <= rd;
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            close_out();
        end
    end
    always @(negedge clk_i) begin
        if (rd_seen && exp_q.size() > 0) begin
            check(rdata, exp_q.pop_front());
        end
    end
    // ****
    // Scenarios.
    // ****
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        check({31'h0, rem_lamp}, 32'h1);
        check({31'h0, arm_lamp}, 32'h0);
        bus_rd(`TLR_A_CTRL, {24'h0, `TLR_CTRL_RST});
        bus_rd(8'h80, 32'h0);
        // Software reloads the retained slot after power-up, so no store is ever read back unknown.
        bus_wr(`TLR_A_POSP, 32'h00000123);
        bus_wr(`TLR_A_POST, 32'h00000045);
        bus_rd(`TLR_A_POSP, 32'h00000123);
        bus_rd(`TLR_A_POST, 32'h00000045);
        bus_wr(`TLR_A_SCALE, 32'h4);
        spool(7, 1'b1);
        bus_rd(`TLR_A_TIMER, 32'h2);
        bus_wr(`TLR_A_SCALE, 32'h1);
        tlr_keypad_model_inst.press(8, 1'b0);
        bus_rd(`TLR_A_TIMER, 32'h0);
        rng = xs(rng);
        n = int'(rng[3:0]) + 4;
        spool(n, 1'b1);
        spool(3, 1'b0);
        bus_rd(`TLR_A_TIMER, 32'(n - 3));
        tend <= 1'b1;
        spool(5, 1'b1);
        tend <= 1'b0;
        bus_rd(`TLR_A_TIMER, 32'(n - 3));
        tlr_keypad_model_inst.press(16, 1'b0);
        check({31'h0, arm_lamp}, 32'h1);
        tlr_keypad_model_inst.press(11, 1'b0);
        check({31'h0, arm_lamp}, 32'h0);
        spool(6, 1'b1);
        tlr_keypad_model_inst.press(11, 1'b0);
        see_drive(4'b0010);
        spool(6, 1'b0);
        see_drive(4'b0000);
        tlr_keypad_model_inst.press(9, 1'b0);
        see_drive(4'b0010);
        tlr_keypad_model_inst.press(6, 1'b0);
        see_drive(4'b0000);
        tlr_keypad_model_inst.press(9, 1'b0);
        tlr_keypad_model_inst.press(2, 1'b0);
        spool(n - 3, 1'b0);
        see_drive(4'b0100);
        bus_rd(`TLR_A_TIMER, 32'h0);
        tlr_keypad_model_inst.press(6, 1'b0);
        bus_wr(`TLR_A_TIMER, 32'h000d2f00);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check({31'h0, over}, 32'h1);
        check({31'h0, under}, 32'h0);
        check({8'h0, disp}, 32'h000d2f00);
        bus_wr(`TLR_A_TIMER, 32'h00fa81c0);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check({31'h0, under}, 32'h1);
        check({31'h0, over}, 32'h0);
        check({8'h0, disp}, 32'h00fa81c0);
        tlr_keypad_model_inst.press(17, 1'b0);
        @(negedge clk_i);
        check({31'h0, aux_ind}, 32'h1);
        check({8'h0, disp}, 32'h00000001);
        check({31'h0, over | under}, 32'h0);
        bus_wr(`TLR_A_CTRL, 32'h1);
        tlr_keypad_model_inst.press(19, 1'b0);
        check({31'h0, rem_lamp}, 32'h1);
        tlr_keypad_model_inst.press(2, 1'b0);
        see_drive(4'b0000);
        tlr_keypad_model_inst.press(2, 1'b1);
        see_drive(4'b0100);
        tlr_keypad_model_inst.press(6, 1'b1);
        see_drive(4'b0000);
        repeat (4) @(posedge clk_i);
        close_out();
    end
endmodule // tb_tape_locator_timer_remote
`default_nettype wire

//--- verif/tlr_keypad_model.sv
`default_nettype none
// ****
// Operator keypad and parallel remote: key levels only, one press at a time.
// ****
module tlr_keypad_model import tlr_pkg::*; (
    input wire logic clk_i,
    output tlr_keys_s local_keys_o,
    output tlr_keys_s par_keys_o,
    output logic [7:0] ser_keys_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        local_keys_o = '0;
        par_keys_o = '0;
        ser_keys_o = 8'h00;
    end
    // Keys are released for two cycles so the next press is seen as a new edge.
    task automatic press(input int idx, input bit remote);
        @(posedge clk_i);
        if (remote) begin
            par_keys_o[idx] <= 1'b1;
        end else begin
            local_keys_o[idx] <= 1'b1;
        end
        repeat (2) @(posedge clk_i);
        local_keys_o <= '0;
        par_keys_o <= '0;
        repeat (2) @(posedge clk_i);
    endtask
endmodule // tlr_keypad_model
`default_nettype wire
